//--- inc/pcab_pkg.sv
// Purpose: shared constants and types of the configuration-cycle initiator with abnormal-termination handling
// Assumes: 32-bit register port, PCI pins sampled on the 10 MHz system clock
// Notes: reserved register bits read as zero
//
// What this block does
// - config read with system error returns all ones and sets read system-error flag
// - config write with system error sets write system-error flag
// - master abort: read returns all ones; write sets write master-abort flag
// - config read ended by retry is reissued automatically until it completes
// - config write ended by retry is reissued up to a fixed build-time count
// - final permitted write retry ending in retry sets burst-write-retry flag
// - disconnect with data completes normally for reads and writes, no flag
// - read data parity error: data still delivered, read parity flag set
// - write data parity error: transaction completes, write parity flag set
// - latency timer expiry never cuts short the single data transfer
// - read target abort returns all ones and sets read target-abort flag
// - write target abort sets write target-abort flag
// - monitor bits 0..5 carry FRAME, DEVSEL, TRDY, IRDY, STOP, IDSEL
// - monitor bit 6 INTA, 7 PERR, 8 SERR, 9 REQ, 10 GNT
// - monitor bit 11 PAR, 12..43 AD[31:0], 44..47 C/BE[3:0]
// - monitor taken from buffered pins, REQ bit from its own output register; clocks and local interrupt request excluded
package pcab_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] REG_CFG_ADDR = 8'h00;
   localparam logic [7:0] REG_CFG_DATA = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_LAT = 8'h10;
   localparam logic [7:0] REG_RETRY = 8'h14;

   localparam int unsigned CTRL_RD_GO = 0;
   localparam int unsigned CTRL_BE_LO = 4;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_FLAGS_LO = 1;

   localparam int unsigned NUM_FLAGS = 9;
   localparam int unsigned F_RD_SERR = 0;
   localparam int unsigned F_WR_SERR = 1;
   localparam int unsigned F_WR_MABORT = 2;
   localparam int unsigned F_WR_RETRY = 3;
   localparam int unsigned F_RD_PERR = 4;
   localparam int unsigned F_WR_PERR = 5;
   localparam int unsigned F_RD_TABORT = 6;
   localparam int unsigned F_WR_TABORT = 7;
   localparam int unsigned F_LAT_EXP = 8;

   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] WR_RETRY_MAX = 4'h8;
   localparam logic [2:0] DEVSEL_WAIT = 3'h5;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [3:0] BE_RST = 4'h0;
   localparam logic [47:0] PIN_RST = 48'hFFFF_FFFF_FFFF;

   localparam int unsigned MON_FRAME = 0;
   localparam int unsigned MON_DEVSEL = 1;
   localparam int unsigned MON_TRDY = 2;
   localparam int unsigned MON_IRDY = 3;
   localparam int unsigned MON_STOP = 4;
   localparam int unsigned MON_IDSEL = 5;
   localparam int unsigned MON_INTA = 6;
   localparam int unsigned MON_PERR = 7;
   localparam int unsigned MON_SERR = 8;
   localparam int unsigned MON_REQ = 9;
   localparam int unsigned MON_GNT = 10;
   localparam int unsigned MON_PAR = 11;
   localparam int unsigned MON_AD_LO = 12;
   localparam int unsigned MON_CBE_LO = 44;
   localparam int unsigned MON_W = 48;

   localparam int unsigned SY_PCLK = 0;
   localparam int unsigned SY_FRAME = 1;
   localparam int unsigned SY_IRDY = 2;
   localparam int unsigned SY_DEVSEL = 3;
   localparam int unsigned SY_TRDY = 4;
   localparam int unsigned SY_STOP = 5;
   localparam int unsigned SY_IDSEL = 6;
   localparam int unsigned SY_INTA = 7;
   localparam int unsigned SY_PERR = 8;
   localparam int unsigned SY_SERR = 9;
   localparam int unsigned SY_GNT = 10;
   localparam int unsigned SY_PAR = 11;
   localparam int unsigned SY_AD_LO = 12;
   localparam int unsigned SY_CBE_LO = 44;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_REQ = 3'b001,
      S_ADDR = 3'b010,
      S_DATA = 3'b011,
      S_TURN = 3'b100,
      S_POST = 3'b101
   } pcab_state_t;

   typedef enum logic [1:0] {
      R_OK = 2'b00,
      R_RETRY = 2'b01,
      R_TABORT = 2'b10,
      R_MABORT = 2'b11
   } pcab_res_t;
endpackage

//--- design/pcab_sync.sv
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: each bit is an independent level; no multi-bit coherence
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module pcab_sync #(
   parameter int unsigned W = 48,
   parameter logic [47:0] RST_VAL = pcab_pkg::PIN_RST
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pcab_sync_st_t;

   pcab_sync_st_t st_q;
   pcab_sync_st_t st_d;

   always_comb begin
      st_d.s1 = D;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
      end else begin
         st_q <= st_d;
      end
   end

   assign Q = st_q.s2;
endmodule // pcab_sync
`default_nettype wire

//--- design/pcab_cfg_init.sv
// Purpose: issues single configuration reads/writes on the PCI bus and reports abnormal endings
// Assumes: PCI clock far slower than CLK; bus pins sampled after two flops
// Notes: pin outputs change a few CLK cycles after each detected PCI clock rise
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pcab_cfg_init (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic PCLK,
   input wire logic GNT_N,
   output logic REQ_N,
   input wire logic FRAME_N_I,
   output logic FRAME_N_O,
   output logic FRAME_N_OE,
   input wire logic IRDY_N_I,
   output logic IRDY_N_O,
   output logic IRDY_N_OE,
   input wire logic DEVSEL_N,
   input wire logic TRDY_N,
   input wire logic STOP_N,
   input wire logic IDSEL,
   input wire logic INTA_N,
   input wire logic PERR_N,
   input wire logic SERR_N,
   input wire logic PAR_I,
   output logic PAR_O,
   output logic PAR_OE,
   input wire logic [31:0] AD_I,
   output logic [31:0] AD_O,
   output logic AD_OE,
   input wire logic [3:0] CBE_N_I,
   output logic [3:0] CBE_N_O,
   output logic CBE_N_OE,
   output logic [47:0] MON
);
   typedef struct packed {
      pcab_pkg::pcab_state_t st;
      pcab_pkg::pcab_res_t res;
      logic [31:0] cfg_addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [3:0] be;
      logic is_wr;
      logic [8:0] flags;
      logic [7:0] lat;
      logic [7:0] lat_cnt;
      logic [3:0] retry_cnt;
      logic [2:0] ms_cnt;
      logic serr_seen;
      logic perr_seen;
      logic pclk_d;
      logic [31:0] bus_rdata;
      logic [47:0] mon;
      logic req_n;
      logic frame_o;
      logic frame_oe;
      logic irdy_o;
      logic irdy_oe;
      logic [31:0] ad_o;
      logic ad_oe;
      logic [3:0] cbe_o;
      logic cbe_oe;
      logic par_o;
      logic par_oe;
   } pcab_cfg_st_t;

   localparam pcab_cfg_st_t ST_RST = '{
      st: pcab_pkg::S_IDLE,
      res: pcab_pkg::R_OK,
      cfg_addr: 32'h0000_0000,
      wdata: 32'h0000_0000,
      rdata: 32'h0000_0000,
      be: pcab_pkg::BE_RST,
      is_wr: 1'b0,
      flags: 9'h000,
      lat: pcab_pkg::LAT_RST,
      lat_cnt: 8'h00,
      retry_cnt: 4'h0,
      ms_cnt: 3'h0,
      serr_seen: 1'b0,
      perr_seen: 1'b0,
      pclk_d: 1'b1,
      bus_rdata: 32'h0000_0000,
      mon: pcab_pkg::PIN_RST,
      req_n: 1'b1,
      frame_o: 1'b1,
      frame_oe: 1'b0,
      irdy_o: 1'b1,
      irdy_oe: 1'b0,
      ad_o: 32'h0000_0000,
      ad_oe: 1'b0,
      cbe_o: 4'h0,
      cbe_oe: 1'b0,
      par_o: 1'b0,
      par_oe: 1'b0
   };

   pcab_cfg_st_t st_q;
   pcab_cfg_st_t st_d;
   logic [47:0] sy;

   // even parity over AD and C/BE, as driven and as checked
   function automatic logic par36(input logic [31:0] d, input logic [3:0] c);
      return ^{d, c};
   endfunction

   pcab_sync #(
      .W(48),
      .RST_VAL(pcab_pkg::PIN_RST)
   ) u_sync (
      .CLK(CLK),
      .RSTN(RSTN),
      .D({CBE_N_I, AD_I, PAR_I, GNT_N, SERR_N, PERR_N, INTA_N, IDSEL, STOP_N,
          TRDY_N, DEVSEL_N, IRDY_N_I, FRAME_N_I, PCLK}),
      .Q(sy)
   );

   always_comb begin
      logic rise;
      logic idle;
      logic [8:0] set_v;
      logic [8:0] clr_v;
      logic serr_now;
      logic perr_now;
      logic done;
      logic reissue;
      logic end_ph;
      set_v = 9'h000;
      clr_v = 9'h000;
      done = 1'b0;
      reissue = 1'b0;
      end_ph = 1'b0;
      st_d = st_q;
      rise = sy[pcab_pkg::SY_PCLK] & ~st_q.pclk_d;
      idle = (st_q.st == pcab_pkg::S_IDLE);
      serr_now = st_q.serr_seen | ~sy[pcab_pkg::SY_SERR];
      perr_now = st_q.perr_seen | (st_q.is_wr & ~sy[pcab_pkg::SY_PERR]);
      st_d.pclk_d = sy[pcab_pkg::SY_PCLK];

      // observation copy of the buffered pins and the own REQ register; nothing here feeds back
      st_d.mon[pcab_pkg::MON_FRAME] = sy[pcab_pkg::SY_FRAME];
      st_d.mon[pcab_pkg::MON_DEVSEL] = sy[pcab_pkg::SY_DEVSEL];
      st_d.mon[pcab_pkg::MON_TRDY] = sy[pcab_pkg::SY_TRDY];
      st_d.mon[pcab_pkg::MON_IRDY] = sy[pcab_pkg::SY_IRDY];
      st_d.mon[pcab_pkg::MON_STOP] = sy[pcab_pkg::SY_STOP];
      st_d.mon[pcab_pkg::MON_IDSEL] = sy[pcab_pkg::SY_IDSEL];
      st_d.mon[pcab_pkg::MON_INTA] = sy[pcab_pkg::SY_INTA];
      st_d.mon[pcab_pkg::MON_PERR] = sy[pcab_pkg::SY_PERR];
      st_d.mon[pcab_pkg::MON_SERR] = sy[pcab_pkg::SY_SERR];
      st_d.mon[pcab_pkg::MON_REQ] = st_q.req_n;
      st_d.mon[pcab_pkg::MON_GNT] = sy[pcab_pkg::SY_GNT];
      st_d.mon[pcab_pkg::MON_PAR] = sy[pcab_pkg::SY_PAR];
      st_d.mon[pcab_pkg::MON_AD_LO +: 32] = sy[pcab_pkg::SY_AD_LO +: 32];
      // clocks and the local interrupt request have no place in the vector
      st_d.mon[pcab_pkg::MON_CBE_LO +: 4] = sy[pcab_pkg::SY_CBE_LO +: 4];

      // register port: read data valid only in the cycle after RD
      st_d.bus_rdata = 32'h0000_0000;
      if (RD) begin
         unique case (ADDR)
            pcab_pkg::REG_CFG_ADDR: st_d.bus_rdata = st_q.cfg_addr;
            pcab_pkg::REG_CFG_DATA: st_d.bus_rdata = st_q.rdata;
            pcab_pkg::REG_CTRL: st_d.bus_rdata[pcab_pkg::CTRL_BE_LO +: 4] = st_q.be;
            pcab_pkg::REG_STATUS: begin
               st_d.bus_rdata[pcab_pkg::ST_BUSY] = ~idle;
               st_d.bus_rdata[pcab_pkg::ST_FLAGS_LO +: pcab_pkg::NUM_FLAGS] = st_q.flags;
            end
            pcab_pkg::REG_LAT: st_d.bus_rdata[7:0] = st_q.lat;
            pcab_pkg::REG_RETRY: st_d.bus_rdata[3:0] = st_q.retry_cnt;
            default: st_d.bus_rdata = 32'h0000_0000;
         endcase
      end

      if (WR) begin
         if (ADDR == pcab_pkg::REG_STATUS) begin
            clr_v = WDATA[pcab_pkg::ST_FLAGS_LO +: pcab_pkg::NUM_FLAGS];
         end
         if (ADDR == pcab_pkg::REG_LAT) begin
            st_d.lat = WDATA[7:0];
         end
         // set-up registers are frozen while a cycle is in flight
         if (idle) begin
            if (ADDR == pcab_pkg::REG_CFG_ADDR) begin
               st_d.cfg_addr = WDATA;
            end
            if (ADDR == pcab_pkg::REG_CTRL) begin
               st_d.be = WDATA[pcab_pkg::CTRL_BE_LO +: 4];
               if (WDATA[pcab_pkg::CTRL_RD_GO]) begin
                  st_d.is_wr = 1'b0;
                  st_d.st = pcab_pkg::S_REQ;
               end
            end
            if (ADDR == pcab_pkg::REG_CFG_DATA) begin
               st_d.wdata = WDATA;
               st_d.is_wr = 1'b1;
               st_d.st = pcab_pkg::S_REQ;
            end
            st_d.retry_cnt = 4'h0;
            st_d.serr_seen = 1'b0;
            st_d.perr_seen = 1'b0;
         end
      end

      if (rise) begin
         // PAR trails AD and C/BE by one PCI clock
         st_d.par_o = par36(st_q.ad_o, st_q.cbe_o);
         st_d.par_oe = st_q.ad_oe;
         if (!idle && st_q.st != pcab_pkg::S_REQ) begin
            st_d.serr_seen = serr_now;
         end
      end

      unique case (st_q.st)
         pcab_pkg::S_IDLE: begin
         end
         pcab_pkg::S_REQ: begin
            if (rise) begin
               if (st_q.req_n) begin
                  st_d.req_n = 1'b0;
               end else if (!sy[pcab_pkg::SY_GNT] && sy[pcab_pkg::SY_FRAME] && sy[pcab_pkg::SY_IRDY]) begin
                  st_d.req_n = 1'b1;
                  st_d.frame_o = 1'b0;
                  st_d.frame_oe = 1'b1;
                  st_d.ad_o = st_q.cfg_addr;
                  st_d.ad_oe = 1'b1;
                  st_d.cbe_o = st_q.is_wr ? pcab_pkg::CMD_CFG_WR : pcab_pkg::CMD_CFG_RD;
                  st_d.cbe_oe = 1'b1;
                  st_d.lat_cnt = st_q.lat;
                  st_d.st = pcab_pkg::S_ADDR;
               end
            end
         end
         pcab_pkg::S_ADDR: begin
            if (rise) begin
               // single data phase: FRAME drops at once, so the timer can never end it early
               st_d.frame_o = 1'b1;
               st_d.irdy_o = 1'b0;
               st_d.irdy_oe = 1'b1;
               st_d.cbe_o = st_q.be;
               st_d.ad_o = st_q.wdata;
               st_d.ad_oe = st_q.is_wr;
               st_d.ms_cnt = 3'h0;
               st_d.st = pcab_pkg::S_DATA;
            end
         end
         pcab_pkg::S_DATA: begin
            if (rise) begin
               if (st_q.lat_cnt != 8'h00) begin
                  st_d.lat_cnt = 8'(st_q.lat_cnt - 8'h01);
                  set_v[pcab_pkg::F_LAT_EXP] = (st_q.lat_cnt == 8'h01);
               end
               st_d.ms_cnt = 3'(st_q.ms_cnt + 3'h1);
               if (!sy[pcab_pkg::SY_DEVSEL] && !sy[pcab_pkg::SY_TRDY]) begin
                  // data moved; a STOP alongside is a disconnect with data
                  st_d.res = pcab_pkg::R_OK;
                  if (!st_q.is_wr) begin
                     st_d.rdata = sy[pcab_pkg::SY_AD_LO +: 32];
                  end
                  end_ph = 1'b1;
               end else if (!sy[pcab_pkg::SY_STOP] && !sy[pcab_pkg::SY_DEVSEL]) begin
                  st_d.res = pcab_pkg::R_RETRY;
                  end_ph = 1'b1;
               end else if (!sy[pcab_pkg::SY_STOP]) begin
                  st_d.res = pcab_pkg::R_TABORT;
                  end_ph = 1'b1;
               end else if (sy[pcab_pkg::SY_DEVSEL] && 3'(st_q.ms_cnt + 3'h1) == pcab_pkg::DEVSEL_WAIT) begin
                  st_d.res = pcab_pkg::R_MABORT;
                  end_ph = 1'b1;
               end
               if (end_ph) begin
                  st_d.irdy_o = 1'b1;
                  st_d.ad_oe = 1'b0;
                  st_d.cbe_oe = 1'b0;
                  st_d.st = pcab_pkg::S_TURN;
               end
            end
         end
         pcab_pkg::S_TURN: begin
            if (rise) begin
               st_d.irdy_oe = 1'b0;
               st_d.frame_oe = 1'b0;
               st_d.perr_seen = perr_now;
               if (!st_q.is_wr && st_q.res == pcab_pkg::R_OK && par36(st_q.rdata, st_q.be) != sy[pcab_pkg::SY_PAR]) begin
                  set_v[pcab_pkg::F_RD_PERR] = 1'b1;
               end
               st_d.st = pcab_pkg::S_POST;
            end
         end
         pcab_pkg::S_POST: begin
            if (rise) begin
               // system error outranks the termination seen on the bus
               if (serr_now) begin
                  if (st_q.is_wr) begin
                     set_v[pcab_pkg::F_WR_SERR] = 1'b1;
                  end else begin
                     st_d.rdata = pcab_pkg::ALL_ONES;
                     set_v[pcab_pkg::F_RD_SERR] = 1'b1;
                  end
                  done = 1'b1;
               end else begin
                  unique case (st_q.res)
                     pcab_pkg::R_OK: begin
                        set_v[pcab_pkg::F_WR_PERR] = perr_now;
                        done = 1'b1;
                     end
                     pcab_pkg::R_RETRY: begin
                        if (!st_q.is_wr) begin
                           reissue = 1'b1;
                        end else if (st_q.retry_cnt == pcab_pkg::WR_RETRY_MAX) begin
                           // the local master must issue the write again itself
                           set_v[pcab_pkg::F_WR_RETRY] = 1'b1;
                           done = 1'b1;
                        end else begin
                           st_d.retry_cnt = 4'(st_q.retry_cnt + 4'h1);
                           reissue = 1'b1;
                        end
                     end
                     pcab_pkg::R_TABORT: begin
                        if (st_q.is_wr) begin
                           set_v[pcab_pkg::F_WR_TABORT] = 1'b1;
                        end else begin
                           st_d.rdata = pcab_pkg::ALL_ONES;
                           set_v[pcab_pkg::F_RD_TABORT] = 1'b1;
                        end
                        done = 1'b1;
                     end
                     pcab_pkg::R_MABORT: begin
                        if (st_q.is_wr) begin
                           set_v[pcab_pkg::F_WR_MABORT] = 1'b1;
                        end else begin
                           st_d.rdata = pcab_pkg::ALL_ONES;
                        end
                        done = 1'b1;
                     end
                  endcase
               end
               if (reissue) begin
                  st_d.serr_seen = 1'b0;
                  st_d.perr_seen = 1'b0;
                  st_d.st = pcab_pkg::S_REQ;
               end
               if (done) begin
                  st_d.st = pcab_pkg::S_IDLE;
               end
            end
         end
         default: st_d = ST_RST;
      endcase

      // a flag raised in the same cycle as its clear survives
      st_d.flags = (st_q.flags & ~clr_v) | set_v;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign RDATA = st_q.bus_rdata;
   assign REQ_N = st_q.req_n;
   assign FRAME_N_O = st_q.frame_o;
   assign FRAME_N_OE = st_q.frame_oe;
   assign IRDY_N_O = st_q.irdy_o;
   assign IRDY_N_OE = st_q.irdy_oe;
   assign PAR_O = st_q.par_o;
   assign PAR_OE = st_q.par_oe;
   assign AD_O = st_q.ad_o;
   assign AD_OE = st_q.ad_oe;
   assign CBE_N_O = st_q.cbe_o;
   assign CBE_N_OE = st_q.cbe_oe;
   assign MON = st_q.mon;
endmodule // pcab_cfg_init
`default_nettype wire

//--- test/pcab_assertions.sv
// Purpose: pin monitor checks for the config initiator
// Assumes: pins reach the monitor three CLK edges late
// Notes: REQ bit is the own register, one edge late
`timescale 1ns/1ps
`default_nettype none
module pcab_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic FRAME_N_I,
   input wire logic IRDY_N_I,
   input wire logic DEVSEL_N,
   input wire logic TRDY_N,
   input wire logic STOP_N,
   input wire logic IDSEL,
   input wire logic INTA_N,
   input wire logic PERR_N,
   input wire logic SERR_N,
   input wire logic REQ_N,
   input wire logic GNT_N,
   input wire logic PAR_I,
   input wire logic [31:0] AD_I,
   input wire logic [3:0] CBE_N_I,
   input wire logic [47:0] MON
);
   logic [1:0] up_q;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // history from inside reset is not what the monitor shows
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   mon_ctrl_a: assert property (
      up_q == 2'h3 |-> MON[4:0] == $past({STOP_N, IRDY_N_I, TRDY_N, DEVSEL_N, FRAME_N_I}, 3))
      else $error("monitor control bits wrong");
   mon_idsel_a: assert property ($rose(IDSEL) |-> ##3 $rose(MON[5]))
      else $error("monitor select bit wrong");
   mon_inta_a: assert property ($fell(INTA_N) |-> ##3 $fell(MON[6]))
      else $error("monitor interrupt bit wrong");
   mon_err_a: assert property (up_q == 2'h3 |-> MON[8:7] == $past({SERR_N, PERR_N}, 3))
      else $error("monitor error bits wrong");
   mon_req_a: assert property (1'b1 |=> MON[9] == $past(REQ_N))
      else $error("monitor request bit wrong");
   mon_gnt_a: assert property (!GNT_N ##1 !GNT_N |-> ##2 !MON[10] ##1 !MON[10])
      else $error("monitor grant bit wrong");
   mon_par_a: assert property (up_q == 2'h3 |-> MON[11] == $past(PAR_I, 3))
      else $error("monitor parity bit wrong");
   mon_bus_a: assert property (up_q == 2'h3 |-> MON[47:12] == $past({CBE_N_I, AD_I}, 3))
      else $error("monitor data path wrong");
endmodule // pcab_chk
bind pcab_cfg_init pcab_chk i_pcab_chk (.CLK, .RSTN, .FRAME_N_I, .IRDY_N_I, .DEVSEL_N, .TRDY_N, .STOP_N,
   .IDSEL, .INTA_N, .PERR_N, .SERR_N, .REQ_N, .GNT_N, .PAR_I, .AD_I, .CBE_N_I, .MON);
`default_nettype wire

//--- test/pcab_tgt.sv
// Purpose: behavioural PCI target and arbiter
// Assumes: acts on PCLK fall so answers hold across the rise
// Notes: mode 0 ok,1 retry,2 abort,3 none,4 serr,5 perr,6 disconnect
`timescale 1ns/1ps
`default_nettype none
module pcab_tgt #(
   parameter logic [31:0] RDV = 32'h0000_0000
) (
   input wire logic pclk,
   input wire logic rstn,
   input wire logic arm,
   input wire logic [2:0] mode,
   input wire logic [3:0] nret,
   input wire logic req_n,
   input wire logic irdy_n,
   input wire logic ad_oe,
   input wire logic [31:0] ad,
   input wire logic [3:0] cbe_n,
   output logic gnt_n,
   output logic devsel_n,
   output logic trdy_n,
   output logic stop_n,
   output logic perr_n,
   output logic serr_n,
   output logic [31:0] t_ad,
   output logic t_par,
   output logic [31:0] wdat
);
   logic act, wr, rty;
   logic [3:0] cnt, be;
   assign rty = (mode == 3'h1) && (cnt < nret);
   always @(negedge pclk or negedge rstn) begin
      if (!rstn) begin
         {act, wr, cnt, be, t_par, t_ad, wdat} <= '0;
         {gnt_n, devsel_n, trdy_n, stop_n, perr_n, serr_n} <= 6'h3F;
      end else begin
         gnt_n <= req_n;
         if (!arm) cnt <= 4'h0;
         if (!irdy_n && !act) begin
            act <= 1'b1;
            cnt <= cnt + 4'h1;
            wr <= ad_oe;
            be <= cbe_n;
            if (ad_oe) wdat <= ad;
            else t_ad <= {RDV[31:3], RDV[2:0] ^ mode};
            devsel_n <= mode == 3'h2 || mode == 3'h3;
            trdy_n <= rty || mode == 3'h2 || mode == 3'h3;
            stop_n <= !(rty || mode == 3'h2 || mode == 3'h6);
            serr_n <= mode != 3'h4;
         end else if (irdy_n && act) begin
            act <= 1'b0;
            {devsel_n, trdy_n, stop_n, serr_n} <= 4'hF;
            t_par <= ^{t_ad, be} ^ (mode == 3'h5);
            perr_n <= !(wr && mode == 3'h5);
         end else if (irdy_n) begin
            // released data path: no pull-up, so keep it moving
            perr_n <= 1'b1;
            t_ad <= ~t_ad;
            t_par <= ~t_par;
         end
      end
   end
endmodule // pcab_tgt
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench for the config initiator
// Assumes: 10 MHz CLK, 800 ns PCI clock, behavioural target
// Notes: latency-timer flag is masked out of status checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] DW = 32'h5A5A_0F0F;
   localparam logic [31:0] RDV = 32'hC3C3_1234;
   logic CLK = 1'b0;
   logic PCLK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0000_0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic IDSEL = 1'b0;
   logic INTA_N = 1'b1;
   logic arm = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [3:0] nret = 4'h0;
   logic [31:0] RDATA, AD_O, AD_I, t_ad, wdat;
   logic REQ_N, GNT_N, FRAME_N_O, FRAME_N_OE, IRDY_N_O, IRDY_N_OE, DEVSEL_N, TRDY_N, STOP_N, t_par;
   logic PERR_N, SERR_N, PAR_O, PAR_OE, PAR_I, AD_OE, CBE_N_OE, FRAME_N_I, IRDY_N_I;
   logic [3:0] CBE_N_O, CBE_N_I;
   logic [47:0] MON;
   int n_mismatch = 0;
   int comparisons = 0;
   assign FRAME_N_I = FRAME_N_OE ? FRAME_N_O : 1'b1;
   assign IRDY_N_I = IRDY_N_OE ? IRDY_N_O : 1'b1;
   assign AD_I = AD_OE ? AD_O : t_ad;
   assign PAR_I = PAR_OE ? PAR_O : t_par;
   assign CBE_N_I = CBE_N_OE ? CBE_N_O : t_ad[3:0];
   pcab_cfg_init i_pcab_cfg_init (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .PCLK, .GNT_N, .REQ_N,
      .FRAME_N_I, .FRAME_N_O, .FRAME_N_OE, .IRDY_N_I, .IRDY_N_O, .IRDY_N_OE, .DEVSEL_N, .TRDY_N, .STOP_N,
      .IDSEL, .INTA_N, .PERR_N, .SERR_N, .PAR_I, .PAR_O, .PAR_OE, .AD_I, .AD_O, .AD_OE, .CBE_N_I,
      .CBE_N_O, .CBE_N_OE, .MON);
   pcab_tgt #(.RDV(RDV)) i_pcab_tgt (.pclk(PCLK), .rstn(RSTN), .arm, .mode, .nret, .req_n(REQ_N),
      .irdy_n(IRDY_N_I), .ad_oe(AD_OE), .ad(AD_I), .cbe_n(CBE_N_I), .gnt_n(GNT_N), .devsel_n(DEVSEL_N),
      .trdy_n(TRDY_N), .stop_n(STOP_N), .perr_n(PERR_N), .serr_n(SERR_N), .t_ad, .t_par, .wdat);
   initial begin
      forever #50 CLK = ~CLK;
   end
   initial begin
      #37;
      forever #400 PCLK = ~PCLK;
   end
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic mon_chk(input logic ids, input logic ia);
      @(posedge CLK);
      IDSEL <= ids;
      INTA_N <= ia;
      @(negedge PCLK);
      repeat (5) @(posedge CLK);
      #1 chk(MON, {CBE_N_I, AD_I, PAR_I, GNT_N, REQ_N, SERR_N, PERR_N, INTA_N, IDSEL, STOP_N, IRDY_N_I,
         TRDY_N, DEVSEL_N, FRAME_N_I});
   endtask
   task automatic run(input logic w, input logic [2:0] m, input logic [3:0] n, input logic [31:0] ef);
      logic [31:0] d;
      mode <= m;
      nret <= n;
      arm <= 1'b0;
      wr(8'h0C, 32'h0000_03FE);
      repeat (8) @(posedge CLK);
      arm <= 1'b1;
      // data differs per mode so a stale result cannot pass
      if (w) wr(8'h04, {DW[31:3], DW[2:0] ^ m});
      else wr(8'h08, 32'h0000_0031);
      d = 32'h0000_0001;
      for (int k = 0; k < 900 && d[0]; k++) rd(8'h0C, d);
      chk(d & 32'h0000_01FF, ef);
      if (!w) begin
         rd(8'h04, d);
         chk(d, (m inside {3'h2, 3'h3, 3'h4}) ? 32'hFFFF_FFFF
            : {RDV[31:3], RDV[2:0] ^ m});
      end else if (m inside {3'h0, 3'h5, 3'h6}) chk(wdat, {DW[31:3], DW[2:0] ^ m});
      if (w && m == 3'h1) begin
         rd(8'h14, d);
         chk(d, (n > pcab_pkg::WR_RETRY_MAX) ? 32'(pcab_pkg::WR_RETRY_MAX) : 32'(n));
      end
   endtask
   initial begin
      logic [31:0] d;
      repeat (20) @(posedge CLK);
      RSTN <= 1'b1;
      wr(8'h18, DW);
      for (int i = 0; i < 4; i++) begin
         rd(8'h0C + 8'(4 * i), d);
         chk(d, 32'h0000_0000);
      end
      wr(8'h10, 32'h0000_0001);
      rd(8'h10, d);
      chk(d, 32'h0000_0001);
      mon_chk(1'b1, 1'b0);
      mon_chk(1'b0, 1'b1);
      run(1'b0, 3'h0, 4'h0, 32'h0000_0000);
      run(1'b0, 3'h1, 4'h3, 32'h0000_0000);
      run(1'b0, 3'h2, 4'h0, 32'h0000_0080);
      run(1'b0, 3'h3, 4'h0, 32'h0000_0000);
      run(1'b0, 3'h4, 4'h0, 32'h0000_0002);
      run(1'b0, 3'h5, 4'h0, 32'h0000_0020);
      run(1'b0, 3'h6, 4'h0, 32'h0000_0000);
      run(1'b1, 3'h1, 4'h3, 32'h0000_0000);
      run(1'b1, 3'h1, 4'h9, 32'h0000_0010);
      run(1'b1, 3'h0, 4'h0, 32'h0000_0000);
      run(1'b1, 3'h2, 4'h0, 32'h0000_0100);
      run(1'b1, 3'h3, 4'h0, 32'h0000_0008);
      run(1'b1, 3'h4, 4'h0, 32'h0000_0004);
      run(1'b1, 3'h5, 4'h0, 32'h0000_0040);
      run(1'b1, 3'h6, 4'h0, 32'h0000_0000);
      end_of_test();
   end
   initial begin
      #8_000_000;
      n_mismatch++;
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
